// *** shared/sfbf_defs.svh ***
// Purpose: constants for the serial fieldbus framer
// Assumes: 200 MHz pclk, APB register access
// Notes: Notes on behaviour follow
//
// Notes on behaviour
// - Transparent mode forwards collected bytes after a fixed 2 ms receive idle gap.
// - Transparent mode pads missing fieldbus input bytes with zero.
// - Transparent mode discards serial bytes beyond the fieldbus input length.
// - Input and output areas are variable length, up to 1440 bytes each.
// - No serial exchange until the fieldbus startup completes without error.
// - With start character set, receiver ignores input until it appears.
// - With start character set, every transmission begins with it.
// - With count byte enabled, receive exactly the counted bytes as one message.
// - With count byte enabled, transmitted count byte equals bytes sent.
// - Without count byte use end criterion, else stop when input area full.
// - Count byte with timeout: expiry before completion discards the partial message.
// - End character FF selects idle timeout, restarted per character, expiry completes.
// - Real end character: message ends with and includes that character.
// - With end character set, it is appended to every transmission.
// - Timeout end criterion makes the count byte setting ignored.
// - Output data copied unchanged with framing added; no acknowledgement sent.
// - Trigger byte enabled: transmit only when it differs from previous value.
// - Output length byte enabled: transmit only that many following bytes.
// - Message longer than block: drop excess and raise receive overrun.
// - Message shorter than block: pad remaining fieldbus bytes with zero.
// - Input length byte enabled: write received useful byte count into it.
// - Input trigger byte enabled: increment it after each complete message.
`ifndef SFBF_DEFS_SVH
`define SFBF_DEFS_SVH
`define SFBF_CLK_MHZ 200
`define SFBF_TP_IDLE_US 2000
`define SFBF_TP_IDLE_CYC (`SFBF_TP_IDLE_US * `SFBF_CLK_MHZ)
`define SFBF_MAX_LEN 1440
`define SFBF_TIMEOUT_END 8'hFF
// Register byte addresses
`define SFBF_A_CTRL 12'h000
`define SFBF_A_CHARS 12'h004
`define SFBF_A_LENS 12'h008
`define SFBF_A_RXTO 12'h00C
`define SFBF_A_STAT 12'h010
`define SFBF_A_OUTW 12'h014
`define SFBF_A_INR 12'h018
`define SFBF_A_OUTKICK 12'h01C
// Control fields
`define SFBF_C_UNIV 0
`define SFBF_C_STARTEN 1
`define SFBF_C_ENDEN 2
`define SFBF_C_CNTEN 3
`define SFBF_C_CNTTO 4
`define SFBF_C_TRIGEN 5
`define SFBF_C_LENEN 6
`define SFBF_C_BUSOK 7
`define SFBF_C_CLROVR 8
`define SFBF_CTRL_RST 9'h000
`define SFBF_RXTO_RST 32'h0000_1000
`endif

// *** shared/sfbf_pkg.sv ***
// Purpose: shared types of the serial fieldbus framer
// Assumes: nothing
// Notes: states only; numbers live in the defs header
`default_nettype none
package sfbf_pkg;
  typedef enum {RX_HUNT, RX_COUNT, RX_DATA, RX_DONE} sfbf_rx_type;
  typedef enum {TX_IDLE, TX_START, TX_CNT, TX_DATA, TX_END} sfbf_tx_type;
endpackage : sfbf_pkg
`default_nettype wire

// *** logic/sfbf_idle_timer.sv ***
// Purpose: receive idle gap timer
// Assumes: restart pulses come from pclk logic
// Notes: expires once per armed gap
`default_nettype none
module sfbf_idle_timer #(
  parameter int CW = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic restart,
  input wire logic disarm,
  input wire logic [CW-1:0] limit,
  // Result
  output logic expired
);
  typedef struct packed {
    logic armed;
    logic [CW-1:0] cnt;
    logic exp;
  } sfbf_tim_type;
  sfbf_tim_type s_r, s_nxt;

  // Count while armed; every character restarts the gap
  always_comb begin
    s_nxt = s_r;
    s_nxt.exp = 1'b0;
    if (restart) begin
      s_nxt.armed = 1'b1;
      s_nxt.cnt = '0;
    end else if (disarm) begin
      s_nxt.armed = 1'b0;
    end else if (s_r.armed) begin
      if (s_r.cnt + CW'(1) >= limit) begin
        s_nxt.exp = 1'b1;
        s_nxt.armed = 1'b0;
      end else begin
        s_nxt.cnt = s_r.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign expired = s_r.exp;
endmodule : sfbf_idle_timer
`default_nettype wire

// *** logic/sfbf_area_ram.sv ***
// Purpose: byte storage for one fieldbus data area
// Assumes: single write port, async read by index
// Notes: flip-flops; clear wipes all bytes to zero
`default_nettype none
module sfbf_area_ram #(
  parameter int DEPTH = 1440,
  parameter int AW = 11
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write side
  input wire logic clr,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read side
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } sfbf_ram_type;
  sfbf_ram_type s_r, s_nxt;

  // Clear gives zero padding; a write in the same cycle lands after it
  always_comb begin
    s_nxt = s_r;
    if (clr) begin
      s_nxt.mem = '0;
    end
    if (we && waddr < AW'(DEPTH)) begin
      s_nxt.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata = (raddr < AW'(DEPTH)) ? s_r.mem[raddr] : 8'h00;
endmodule : sfbf_area_ram
`default_nettype wire

// *** logic/sfbf_framer.sv ***
// Purpose: frames serial bytes to and from the fieldbus data areas
// Assumes: byte stream ports from a UART on pclk; APB slave for control
// Notes: fieldbus input area read over APB; output area written over APB
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`include "sfbf_defs.svh"
`default_nettype none
module sfbf_framer
  import sfbf_pkg::*;
#(
  parameter int MAX_LEN = `SFBF_MAX_LEN,
  parameter int AW = 11,
  parameter int TP_IDLE = `SFBF_TP_IDLE_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial receive bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  // Serial transmit bytes
  output logic tx_valid,
  output logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Event outputs
  output logic rx_msg_done,
  output logic rx_overrun
);
  typedef struct packed {
    logic [8:0] ctrl;
    logic [7:0] start_ch;
    logic [7:0] end_ch;
    logic [AW-1:0] in_len;
    logic [AW-1:0] out_len;
    logic [31:0] rxto;
    sfbf_rx_type rxs;
    logic [AW-1:0] rx_idx;
    logic [7:0] rx_need;
    logic [7:0] rx_cnt;
    logic [7:0] trig_in;
    logic ovr;
    logic done;
    sfbf_tx_type txs;
    logic [AW-1:0] tx_idx;
    logic [AW-1:0] tx_n;
    logic [7:0] trig_seen;
    logic [AW-1:0] ow_addr;
    logic [31:0] rdata;
  } sfbf_st_type;
  sfbf_st_type s_r, s_nxt;

  // Data areas and timers
  logic ram_clr, ram_we, out_we, tmo_tp, tmo_u, tim_restart, tim_disarm;
  logic [AW-1:0] ram_wa, ram_ra, out_ra;
  logic [7:0] ram_wd, ram_rd, out_rd;

  // Header byte count in the fieldbus areas
  function automatic logic [AW-1:0] hdr_len(input logic [8:0] c);
    hdr_len = AW'(c[`SFBF_C_UNIV] & c[`SFBF_C_TRIGEN])
            + AW'(c[`SFBF_C_UNIV] & c[`SFBF_C_LENEN]);
  endfunction : hdr_len

  // Room for useful data in the output area
  function automatic logic [AW-1:0] room(input logic [AW-1:0] len, input logic [8:0] c);
    room = (len > hdr_len(c)) ? len - hdr_len(c) : '0;
  endfunction : room

  logic univ, busok, to_end, use_cnt, apb_acc;
  assign univ = s_r.ctrl[`SFBF_C_UNIV];
  assign busok = s_r.ctrl[`SFBF_C_BUSOK];
  assign to_end = s_r.ctrl[`SFBF_C_ENDEN] && (s_r.end_ch == `SFBF_TIMEOUT_END);
  assign use_cnt = s_r.ctrl[`SFBF_C_CNTEN] && !to_end;
  assign apb_acc = psel && penable;

  sfbf_area_ram #(.DEPTH(MAX_LEN), .AW(AW)) u_in_area (
    .pclk(pclk), .presetn(presetn), .clr(ram_clr), .we(ram_we),
    .waddr(ram_wa), .wdata(ram_wd), .raddr(ram_ra), .rdata(ram_rd));
  sfbf_area_ram #(.DEPTH(MAX_LEN), .AW(AW)) u_out_area (
    .pclk(pclk), .presetn(presetn), .clr(1'b0), .we(out_we),
    .waddr(s_r.ow_addr), .wdata(pwdata[7:0]), .raddr(out_ra), .rdata(out_rd));

  // Fixed gap for transparent mode
  sfbf_idle_timer #(.CW(32)) u_tp_timer (
    .pclk(pclk), .presetn(presetn), .restart(tim_restart && !univ),
    .disarm(tim_disarm), .limit(32'(TP_IDLE)), .expired(tmo_tp));
  // Programmable gap for universal mode
  sfbf_idle_timer #(.CW(32)) u_u_timer (
    .pclk(pclk), .presetn(presetn), .restart(tim_restart && univ),
    .disarm(tim_disarm), .limit(s_r.rxto), .expired(tmo_u));

  // Register, receive and transmit logic
  always_comb begin
    logic [AW-1:0] data_pos;
    logic [AW-1:0] tx_pos;
    logic finish, discard;
    data_pos = '0;
    tx_pos = '0;
    finish = 1'b0;
    discard = 1'b0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.ctrl[`SFBF_C_CLROVR] = 1'b0;
    ram_clr = 1'b0;
    ram_we = 1'b0;
    ram_wa = '0;
    ram_wd = 8'h00;
    out_we = 1'b0;
    tim_restart = 1'b0;
    tim_disarm = 1'b0;
    ram_ra = s_r.ow_addr;
    out_ra = '0;

    // Receive path, idle until the bus side is up
    if (busok) begin
      data_pos = s_r.rx_idx + hdr_len(s_r.ctrl);
      case (s_r.rxs)
        RX_HUNT: begin
          if (rx_valid) begin
            if (univ && s_r.ctrl[`SFBF_C_STARTEN]) begin
              if (rx_byte == s_r.start_ch) begin
                s_nxt.rxs = use_cnt ? RX_COUNT : RX_DATA;
                s_nxt.rx_idx = '0;
                ram_clr = 1'b1;
              end
            end else if (univ && use_cnt) begin
              s_nxt.rx_need = rx_byte;
              s_nxt.rx_idx = '0;
              s_nxt.rxs = (rx_byte == 8'h00) ? RX_DONE : RX_DATA;
              ram_clr = 1'b1;
              tim_restart = s_r.ctrl[`SFBF_C_CNTTO];
            end else begin
              ram_clr = 1'b1;
              ram_we = 1'b1;
              ram_wa = hdr_len(s_r.ctrl);
              ram_wd = rx_byte;
              s_nxt.rx_idx = AW'(1);
              s_nxt.rxs = RX_DATA;
              tim_restart = 1'b1;
            end
          end
        end
        RX_COUNT: begin
          if (rx_valid) begin
            s_nxt.rx_need = rx_byte;
            s_nxt.rxs = (rx_byte == 8'h00) ? RX_DONE : RX_DATA;
            tim_restart = s_r.ctrl[`SFBF_C_CNTTO];
          end else if (tmo_u && s_r.ctrl[`SFBF_C_CNTTO]) begin
            discard = 1'b1;
          end
        end
        RX_DATA: begin
          if (rx_valid) begin
            if (data_pos < s_r.in_len) begin
              ram_we = 1'b1;
              ram_wa = data_pos;
              ram_wd = rx_byte;
              s_nxt.rx_idx = s_r.rx_idx + AW'(1);
            end else begin
              s_nxt.ovr = 1'b1;
            end
            s_nxt.rx_cnt = s_r.rx_cnt + 8'h01;
            if (!univ) begin
              tim_restart = 1'b1;
            end else if (use_cnt) begin
              tim_restart = s_r.ctrl[`SFBF_C_CNTTO];
              if (s_r.rx_cnt + 8'h01 == s_r.rx_need) begin
                finish = 1'b1;
              end
            end else if (s_r.ctrl[`SFBF_C_ENDEN] && !to_end) begin
              if (rx_byte == s_r.end_ch) begin
                finish = 1'b1;
              end
            end else if (to_end) begin
              tim_restart = 1'b1;
            end else if (data_pos + AW'(1) >= s_r.in_len) begin
              finish = 1'b1;
            end
          end else if (!univ && tmo_tp) begin
            finish = 1'b1;
          end else if (univ && to_end && tmo_u) begin
            finish = 1'b1;
          end else if (univ && use_cnt && s_r.ctrl[`SFBF_C_CNTTO] && tmo_u) begin
            discard = 1'b1;
          end
        end
        RX_DONE: begin
          finish = 1'b1;
        end
        default: begin
          s_nxt.rxs = RX_HUNT;
        end
      endcase
    end

    // Message completion advances the input trigger byte
    if (finish) begin
      s_nxt.rxs = RX_HUNT;
      s_nxt.rx_cnt = 8'h00;
      s_nxt.done = 1'b1;
      tim_disarm = 1'b1;
      if (univ && s_r.ctrl[`SFBF_C_TRIGEN]) begin
        s_nxt.trig_in = s_r.trig_in + 8'h01;
      end
    end
    if (discard) begin
      s_nxt.rxs = RX_HUNT;
      s_nxt.rx_cnt = 8'h00;
      ram_clr = 1'b1;
      tim_disarm = 1'b1;
    end
    if (s_r.ctrl[`SFBF_C_CLROVR]) begin
      s_nxt.ovr = s_nxt.ovr; // a new overrun in the same cycle wins
    end

    // Transmit path
    tx_pos = s_r.tx_idx + hdr_len(s_r.ctrl);
    out_ra = (s_r.txs == TX_DATA) ? tx_pos : '0;
    case (s_r.txs)
      TX_IDLE: begin
        if (s_r.ctrl[`SFBF_C_BUSOK] && s_r.ctrl[`SFBF_C_CLROVR] == 1'b0) begin
          s_nxt.txs = TX_IDLE;
        end
      end
      TX_START: begin
        if (tx_ready) begin
          s_nxt.txs = use_cnt ? TX_CNT : TX_DATA;
        end
      end
      TX_CNT: begin
        if (tx_ready) begin
          s_nxt.txs = TX_DATA;
        end
      end
      TX_DATA: begin
        if (s_r.tx_idx >= s_r.tx_n ||
            (tx_ready && s_r.tx_idx + AW'(1) >= s_r.tx_n)) begin
          s_nxt.txs = (univ && s_r.ctrl[`SFBF_C_ENDEN] && !to_end) ? TX_END : TX_IDLE;
        end
        if (tx_ready && s_r.tx_idx < s_r.tx_n) begin
          s_nxt.tx_idx = s_r.tx_idx + AW'(1);
        end
      end
      TX_END: begin
        if (tx_ready) begin
          s_nxt.txs = TX_IDLE;
        end
      end
      default: begin
        s_nxt.txs = TX_IDLE;
      end
    endcase

    // APB access, answered in the access cycle
    if (apb_acc && pwrite) begin
      case (paddr)
        `SFBF_A_CTRL: s_nxt.ctrl = pwdata[8:0];
        `SFBF_A_CHARS: begin
          s_nxt.start_ch = pwdata[7:0];
          s_nxt.end_ch = pwdata[15:8];
        end
        `SFBF_A_LENS: begin
          s_nxt.in_len = (pwdata[AW-1:0] > AW'(MAX_LEN)) ? AW'(MAX_LEN) : pwdata[AW-1:0];
          s_nxt.out_len = (pwdata[16+AW-1:16] > AW'(MAX_LEN)) ? AW'(MAX_LEN)
                        : pwdata[16+AW-1:16];
        end
        `SFBF_A_RXTO: s_nxt.rxto = pwdata;
        `SFBF_A_STAT: s_nxt.ow_addr = pwdata[AW-1:0];
        `SFBF_A_OUTW: begin
          out_we = 1'b1;
          s_nxt.ow_addr = s_r.ow_addr + AW'(1);
        end
        `SFBF_A_OUTKICK: begin
          if (busok && s_r.txs == TX_IDLE) begin
            // Trigger byte gates the send; length byte trims it
            if (!(univ && s_r.ctrl[`SFBF_C_TRIGEN]) ||
                pwdata[7:0] != s_r.trig_seen) begin
              s_nxt.trig_seen = pwdata[7:0];
              s_nxt.tx_idx = '0;
              s_nxt.tx_n = room(s_r.out_len, s_r.ctrl);
              if (univ && s_r.ctrl[`SFBF_C_LENEN] &&
                  AW'(pwdata[15:8]) < room(s_r.out_len, s_r.ctrl)) begin
                s_nxt.tx_n = AW'(pwdata[15:8]);
              end
              s_nxt.txs = (univ && s_r.ctrl[`SFBF_C_STARTEN]) ? TX_START
                        : (univ && use_cnt) ? TX_CNT : TX_DATA;
            end
          end
        end
        default: begin
        end
      endcase
    end
    if (apb_acc && pwrite && paddr == `SFBF_A_CTRL && pwdata[`SFBF_C_CLROVR] &&
        !(s_nxt.ovr && !s_r.ovr)) begin
      s_nxt.ovr = 1'b0;
    end
    if (apb_acc && !pwrite && paddr == `SFBF_A_INR) begin
      s_nxt.ow_addr = s_r.ow_addr + AW'(1);
    end

    // Read data capture, input area bytes show the header fields
    s_nxt.rdata = apb_acc ? s_r.rdata : 32'h0000_0000; // Held in access
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `SFBF_A_CTRL: s_nxt.rdata = {23'h000000, s_r.ctrl};
        `SFBF_A_CHARS: s_nxt.rdata = {16'h0000, s_r.end_ch, s_r.start_ch};
        `SFBF_A_LENS: s_nxt.rdata = {5'h00, s_r.out_len, 5'h00, s_r.in_len};
        `SFBF_A_RXTO: s_nxt.rdata = s_r.rxto;
        `SFBF_A_STAT: s_nxt.rdata = {s_r.trig_in, 7'h00, s_r.ovr,
                                     5'h00, s_r.ow_addr};
        `SFBF_A_INR: begin
          if (univ && s_r.ctrl[`SFBF_C_TRIGEN] && s_r.ow_addr == '0) begin
            s_nxt.rdata = {24'h000000, s_r.trig_in};
          end else if (univ && s_r.ctrl[`SFBF_C_LENEN] &&
                       s_r.ow_addr == AW'(s_r.ctrl[`SFBF_C_TRIGEN])) begin
            s_nxt.rdata = {21'h000000, s_r.rx_idx};
          end else begin
            s_nxt.rdata = {24'h000000, ram_rd};
          end
        end
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.rxto <= `SFBF_RXTO_RST;
      s_r.in_len <= AW'(MAX_LEN);
      s_r.out_len <= AW'(MAX_LEN);
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_r.rdata;
  assign tx_valid = (s_r.txs == TX_START) || (s_r.txs == TX_CNT) || (s_r.txs == TX_END)
                 || (s_r.txs == TX_DATA && s_r.tx_idx < s_r.tx_n);
  assign tx_byte = (s_r.txs == TX_START) ? s_r.start_ch
                 : (s_r.txs == TX_CNT) ? s_r.tx_n[7:0]
                 : (s_r.txs == TX_END) ? s_r.end_ch
                 : out_rd;
  assign rx_msg_done = s_r.done;
  assign rx_overrun = s_r.ovr;
endmodule : sfbf_framer
`default_nettype wire

// *** verification/sfbf_framer_chk.sv ***
// Purpose: port-level assertions for the serial fieldbus framer
// Assumes: control words tracked from APB writes seen at the ports
// Notes: bound into every instance of the framer
`default_nettype none
module sfbf_framer_chk #(
  parameter int MAX_LEN = 1440,
  parameter int AW = 11,
  parameter int TP_IDLE = 400000
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Serial bytes
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  input wire logic tx_ready,
  // Events
  input wire logic rx_msg_done,
  input wire logic rx_overrun
);
  logic [8:0] ctrl_r;
  logic [15:0] chars_r;
  logic clr_w;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Shadow of the control words, taken on the access edge as the slave does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= 9'h000;
      chars_r <= 16'h0000;
    end else if (psel && penable && pwrite && paddr == 12'h000) begin
      ctrl_r <= pwdata[8:0];
    end else if (psel && penable && pwrite && paddr == 12'h004) begin
      chars_r <= pwdata[15:0];
    end
  end
  // Clear strobe; a set in the same cycle may still win
  assign clr_w = psel && penable && pwrite && paddr == 12'h000 && pwdata[8];
  sequence s_stall;
    tx_valid && !tx_ready;
  endsequence
  sequence s_frame_open;
    $rose(tx_valid) && ctrl_r[0] && ctrl_r[1];
  endsequence
  property p_gate_tx;
    tx_valid |-> ctrl_r[7];
  endproperty
  a_gate_tx: assert property (p_gate_tx) else $error("transmit before startup done");
  property p_gate_rx;
    rx_msg_done |-> ctrl_r[7];
  endproperty
  a_gate_rx: assert property (p_gate_rx) else $error("message before startup done");
  property p_done_pulse;
    rx_msg_done |=> !rx_msg_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_ovr_sticky;
    rx_overrun && !clr_w |=> rx_overrun;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost without clear");
  property p_tx_hold;
    s_stall |=> tx_valid && $stable(tx_byte);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit byte changed in stall");
  property p_start_first;
    s_frame_open |-> tx_byte == chars_r[7:0];
  endproperty
  a_start_first: assert property (p_start_first) else $error("frame not opened by start");
  property p_end_last;
    $fell(tx_valid) && ctrl_r[0] && ctrl_r[2] && chars_r[15:8] != 8'hFF
      |-> $past(tx_byte) == chars_r[15:8];
  endproperty
  a_end_last: assert property (p_end_last) else $error("frame not closed by end");
  property p_apb_answer;
    psel && penable |-> pready && !pslverr;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer missing");
endmodule : sfbf_framer_chk
bind sfbf_framer sfbf_framer_chk #(.MAX_LEN(MAX_LEN), .AW(AW), .TP_IDLE(TP_IDLE)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
  .tx_ready(tx_ready), .rx_msg_done(rx_msg_done), .rx_overrun(rx_overrun));
`default_nettype wire

// *** verification/sfbf_serial_peer.sv ***
// Purpose: serial equipment facing the framer at byte level
// Assumes: bytes move in the pclk domain
// Notes: idle receive line shows the inverse of the last byte
`default_nettype none
module sfbf_serial_peer (
  // Clock
  input wire logic pclk,
  // Bytes towards the framer
  output logic rx_valid,
  output logic [7:0] rx_byte,
  // Bytes from the framer
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int txq[$];
  int seed = 64275;
  logic [31:0] r;
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    tx_ready = 1'b0;
  end
  // One byte per pulse, stale value never left on the line
  task automatic send(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
    @(posedge pclk);
  endtask : send
  // Random stalls; a byte counts only at a handshake edge
  always @(posedge pclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) txq.push_back(int'(tx_byte));
    r = $random(seed);
    tx_ready <= r[0];
  end
endmodule : sfbf_serial_peer
`default_nettype wire

// *** verification/sfbf_framer_bench.sv ***
// Purpose: self-checking bench for the serial fieldbus framer
// Assumes: short idle gap parameter so timeouts stay brief
// Notes: expected areas come from a queue model of the framing rules
`include "sfbf_defs.svh"
`default_nettype none
module sfbf_framer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef int sfbf_q_type[$];
  localparam int TPI = 50;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rq;
  logic pready, pslverr, rx_valid, tx_valid, tx_ready, rx_msg_done, rx_overrun;
  logic [7:0] rx_byte, tx_byte;
  int fails = 0, n_compared = 0, seed = 64275, trig = 0, waited = 0, got_done = 0;
  sfbf_framer #(.TP_IDLE(TPI)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready),
    .rx_msg_done(rx_msg_done), .rx_overrun(rx_overrun));
  sfbf_serial_peer i_peer (.pclk(pclk), .rx_valid(rx_valid), .rx_byte(rx_byte),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // Done pulses are caught here so a short pulse is never missed
  always @(posedge pclk) begin
    if (rx_msg_done === 1'b1) got_done = 1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  function automatic int rnd();
    return ($random(seed) & 32'h3F) | 32'h40;
  endfunction : rnd
  // Model of the input area: header, truncation, zero padding
  function automatic sfbf_q_type model(sfbf_q_type d, int len, int hdr);
    sfbf_q_type e;
    if (hdr != 0) e = '{trig & 255, d.size()};
    foreach (d[i]) if (e.size() < len) e.push_back(d[i]);
    while (e.size() < len) e.push_back(0);
    return e;
  endfunction : model
  task automatic area(input sfbf_q_type e);
    apb(1'b1, `SFBF_A_STAT, 32'h0);
    foreach (e[i]) begin
      apb(1'b0, `SFBF_A_INR, 32'h0);
      chk({24'h0, rq[7:0]}, 32'(e[i]));
    end
  endtask : area
  task automatic rx_msg(input sfbf_q_type f, input int exp_done);
    got_done = 0;
    foreach (f[i]) i_peer.send(8'(f[i]));
    waited = 0;
    while (got_done == 0 && waited < 200) begin
      @(posedge pclk);
      waited++;
    end
    chk(32'(got_done), 32'(exp_done));
  endtask : rx_msg
  task automatic tx_chk(input sfbf_q_type e);
    int n;
    n = 0;
    while ((i_peer.txq.size() < e.size() || n < 100) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(i_peer.txq.size()), 32'(e.size()));
    foreach (e[i]) if (i < i_peer.txq.size()) chk(32'(i_peer.txq[i]), 32'(e[i]));
    i_peer.txq.delete();
  endtask : tx_chk
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset
  initial begin
    #250000;
    fails++;
    conclude();
  end
  initial begin
    sfbf_q_type d;
    do_reset();
    area('{0, 0});
    apb(1'b0, 12'h020, 32'h0);
    chk(rq, 32'h0);
    // Startup incomplete: bytes must not complete a message
    apb(1'b1, `SFBF_A_LENS, 32'h4);
    rx_msg('{rnd(), rnd()}, 0);
    // Transparent: idle gap, padding, cut-off
    apb(1'b1, `SFBF_A_CTRL, 32'h80);
    d = '{rnd(), rnd()};
    rx_msg(d, 1);
    chk(32'(waited > TPI - 6 && waited < TPI + 4), 32'h1);
    area(model(d, 4, 0));
    d = '{rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    rx_msg(d, 1);
    area(model(d, 4, 0));
    // Universal: start hunt, timeout end, count byte ignored
    apb(1'b1, `SFBF_A_RXTO, 32'd30);
    apb(1'b1, `SFBF_A_CHARS, 32'h0000FF3C);
    apb(1'b1, `SFBF_A_CTRL, 32'h18F);
    d = '{rnd(), rnd(), rnd()};
    rx_msg({17, 60, d}, 1);
    chk(32'(waited > 24 && waited < 34), 32'h1);
    area(model(d, 4, 0));
    // Real end character, then an overrun and its clear
    apb(1'b1, `SFBF_A_CHARS, 32'h00000D3C);
    apb(1'b1, `SFBF_A_CTRL, 32'h87);
    d = '{rnd(), rnd(), 13};
    rx_msg({60, d}, 1);
    area(model(d, 4, 0));
    d = '{rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), 13};
    rx_msg({60, d}, 1);
    area(model(d, 4, 0));
    chk(32'(rx_overrun), 32'h1);
    apb(1'b1, `SFBF_A_CTRL, 32'h187);
    chk(32'(rx_overrun), 32'h0);
    // Reset mid-run, then count byte with trigger and length header
    do_reset();
    chk(32'(rx_overrun), 32'h0);
    apb(1'b1, `SFBF_A_LENS, 32'h0007_0006);
    apb(1'b1, `SFBF_A_RXTO, 32'd30);
    apb(1'b1, `SFBF_A_CTRL, 32'hE9);
    repeat (2) begin
      d = '{rnd(), rnd()};
      rx_msg({2, d}, 1);
      trig++;
      area(model(d, 6, 1));
    end
    // Count byte with timeout: partial message thrown away
    apb(1'b1, `SFBF_A_CTRL, 32'hF9);
    rx_msg('{3, rnd()}, 0);
    d = '{rnd()};
    rx_msg({1, d}, 1);
    trig++;
    area(model(d, 6, 1));
    // Transmit: framing, count byte, output length, trigger change
    apb(1'b1, `SFBF_A_CHARS, 32'h00000D3C);
    apb(1'b1, `SFBF_A_CTRL, 32'hEF);
    apb(1'b1, `SFBF_A_STAT, 32'h2);
    d = '{rnd(), rnd(), rnd(), rnd(), rnd()};
    foreach (d[i]) apb(1'b1, `SFBF_A_OUTW, 32'(d[i]));
    apb(1'b1, `SFBF_A_OUTKICK, 32'h00000301);
    tx_chk('{60, 3, d[0], d[1], d[2], 13});
    apb(1'b1, `SFBF_A_OUTKICK, 32'h00000301);
    tx_chk('{});
    apb(1'b1, `SFBF_A_OUTKICK, 32'h00000402);
    tx_chk('{60, 4, d[0], d[1], d[2], d[3], 13});
    conclude();
  end
endmodule : sfbf_framer_bench
`default_nettype wire
